// ### core/genset_supervisor_defs.vh
// constants for the genset shutdown alarm supervisor
`ifndef GENSET_SUPERVISOR_DEFS_VH
`define GENSET_SUPERVISOR_DEFS_VH

// timebase
`define CLK_PERIOD_NS 8
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES_DEF (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICKS_PER_S 16'h03e8
`define ECU_SILENCE_S 16'h0003
`define KEY_HOLD_S 16'h0005
`define OVER_FREQ_PCT 12
`define PCT_DIV 100

// register byte offsets
`define REG_CTRL 8'h00
`define REG_FREQ_LIM 8'h04
`define REG_RPM_LIM 8'h08
`define REG_RPM_OVER 8'h0c
`define REG_VOLT_LIM 8'h10
`define REG_BATT_LIM 8'h14
`define REG_CHARGE_LIM 8'h18
`define REG_UNBAL_LIM 8'h1c
`define REG_OC_LIM 8'h20
`define REG_DELAY_A 8'h24
`define REG_DELAY_B 8'h28
`define REG_START 8'h2c
`define REG_SERVICE 8'h30
`define REG_STATUS 8'h34
`define REG_SERVICE_USED 8'h38

// reset values
`define WINDOW_RESET 32'hffff0000
`define ZERO_RESET 32'h00000000
`define CTRL_RESET 32'h00000000

// control fields
`define CTRL_ACK 0
`define CTRL_UNBAL_ACT 3:2
`define CTRL_OC_ACT 5:4
`define CTRL_SERVICE_ACT 7:6
`define ACT_WARNING 2'h0
`define ACT_LOADDUMP 2'h1
`define ACT_SHUTDOWN 2'h2

// alarm bits
`define NA 14
`define A_FREQ 0
`define A_RPM 1
`define A_VOLT 2
`define A_BATT 3
`define A_START 4
`define A_STOP 5
`define A_CHARGE 6
`define A_ECU 7
`define A_VUNBAL 8
`define A_IUNBAL 9
`define A_OC 10
`define A_SERVICE 11
`define A_FREQ_OVER 12
`define A_RPM_OVER 13

// timers
`define NT 12
`define T_FREQ 0
`define T_RPM 1
`define T_VOLT 2
`define T_BATT 3
`define T_CHARGE 4
`define T_VUNBAL 5
`define T_IUNBAL 6
`define T_ECU 7
`define T_STOP 8
`define T_KEYS 9
`define T_OC 10
`define T_HOLD 11

`endif

// ### core/genset_shutdown_alarm_supervisor.v
// genset fault supervisor: limit checks, fault timers, latched alarms, apb registers
//
// Function
// - frequency, speed, voltage, charge and unbalance checks wait for running plus hold-off
// - low and high limits of frequency, speed and battery are separate settings
// - frequency, speed and battery violations must persist for the detection delay
// - frequency twelve percent above high limit stops the engine at once
// - speed overshoot limit stops the engine at once, no delays
// - any phase voltage outside window for voltage-fail time raises voltage alarm
// - battery out of limits raises alarm regardless of engine running
// - fail-to-start when still not running after all start attempts
// - fail-to-stop when engine still running at stop timer expiry
// - charge alternator voltage below limit raises low charge alarm
// - no engine controller message for three seconds raises ECU fail
// - ECU silence timer runs only while fuel is on
// - phase voltage deviating from average beyond limit for voltage-fail time
// - phase current deviating from current average beyond limit raises alarm
// - overcurrent alarm after a permitted time shrinking with the excess
// - currents back below limit before expiry abandon the overcurrent timer
// - unbalance and overcurrent actions come from a configuration field
// - service alarm when at least one service counter has expired
// - both keys held five seconds reset service counters and signal completion
// - service fault level selectable; a zero limit disables that counter part
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "genset_supervisor_defs.vh"

module genset_shutdown_alarm_supervisor #(
	parameter TICK_CYCLES = `TICK_CYCLES_DEF
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire engine_running,
	input wire fuel_on,
	input wire ecu_msg,
	input wire start_cmd,
	input wire crank_end,
	input wire stop_cmd,
	input wire hour_tick,
	input wire day_tick,
	input wire [15:0] freq,
	input wire [15:0] rpm,
	input wire [15:0] volt_l1,
	input wire [15:0] volt_l2,
	input wire [15:0] volt_l3,
	input wire [15:0] batt,
	input wire [15:0] charge,
	input wire [15:0] curr_l1,
	input wire [15:0] curr_l2,
	input wire [15:0] curr_l3,
	input wire key_mute,
	input wire key_test,
	output reg [`NA-1:0] alarm_flags,
	output wire warning_alarm,
	output wire loaddump_alarm,
	output wire shutdown_alarm,
	output wire stop_request,
	output wire service_request,
	output reg service_reset_done
);

	localparam [16:0] TICK_LAST = TICK_CYCLES[16:0] - 17'h00001;
	localparam [15:0] ECU_TICKS = `ECU_SILENCE_S * `TICKS_PER_S;
	localparam [15:0] KEY_TICKS = `KEY_HOLD_S * `TICKS_PER_S;

	function out_of_window;
		input [15:0] v;
		input [31:0] lim;
		begin
			out_of_window = (v < lim[15:0]) || (v > lim[31:16]);
		end
	endfunction

	function [15:0] abs_diff;
		input [15:0] a;
		input [15:0] b;
		begin
			abs_diff = (a > b) ? a - b : b - a;
		end
	endfunction

	function [15:0] avg3;
		input [15:0] a;
		input [15:0] b;
		input [15:0] c;
		reg [17:0] s;
		begin
			s = {2'h0, a} + {2'h0, b} + {2'h0, c};
			s = s / 18'h00003;
			avg3 = s[15:0];
		end
	endfunction

	function unbalanced;
		input [15:0] a;
		input [15:0] b;
		input [15:0] c;
		input [15:0] lim;
		reg [15:0] m;
		begin
			m = avg3(a, b, c);
			unbalanced = (abs_diff(a, m) > lim) || (abs_diff(b, m) > lim) ||
				(abs_diff(c, m) > lim);
		end
	endfunction

	// mask of alarm bits that belong to a given action level
	function [`NA-1:0] level_mask;
		input [1:0] lvl;
		input [31:0] ctrl_v;
		reg [`NA-1:0] m;
		begin
			m = {`NA{1'b0}};
			if (lvl == `ACT_SHUTDOWN) begin
				m = {`NA{1'b1}};
				m[`A_VUNBAL] = 1'b0;
				m[`A_IUNBAL] = 1'b0;
				m[`A_OC] = 1'b0;
				m[`A_SERVICE] = 1'b0;
			end
			m[`A_VUNBAL] = (ctrl_v[`CTRL_UNBAL_ACT] == lvl);
			m[`A_IUNBAL] = (ctrl_v[`CTRL_UNBAL_ACT] == lvl);
			m[`A_OC] = (ctrl_v[`CTRL_OC_ACT] == lvl);
			m[`A_SERVICE] = (ctrl_v[`CTRL_SERVICE_ACT] == lvl);
			level_mask = m;
		end
	endfunction

	reg [31:0] ctrl;
	reg [31:0] freq_lim;
	reg [31:0] rpm_lim;
	reg [31:0] rpm_over;
	reg [31:0] volt_lim;
	reg [31:0] batt_lim;
	reg [31:0] charge_lim;
	reg [31:0] unbal_lim;
	reg [31:0] oc_lim;
	reg [31:0] delay_a;
	reg [31:0] delay_b;
	reg [31:0] start_cfg;
	reg [31:0] service_cfg;
	reg [15:0] hours_used;
	reg [15:0] days_used;
	reg [16:0] tick_cnt;
	reg tick;
	reg [3:0] attempts;
	reg [1:0] mute_sync;
	reg [1:0] test_sync;
	reg keys_done_d;
	reg [31:0] next_prdata;
	reg next_pslverr;

	wire wr_en = psel & penable & pwrite;
	wire ack = wr_en && (paddr == `REG_CTRL) && pwdata[`CTRL_ACK];

	assign pready = 1'b1;

	// apb writes take effect on the access-phase edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `CTRL_RESET;
			freq_lim <= `WINDOW_RESET;
			rpm_lim <= `WINDOW_RESET;
			rpm_over <= `WINDOW_RESET;
			volt_lim <= `WINDOW_RESET;
			batt_lim <= `WINDOW_RESET;
			charge_lim <= `ZERO_RESET;
			unbal_lim <= `WINDOW_RESET;
			oc_lim <= `WINDOW_RESET;
			delay_a <= `ZERO_RESET;
			delay_b <= `ZERO_RESET;
			start_cfg <= `ZERO_RESET;
			service_cfg <= `ZERO_RESET;
		end else if (wr_en) begin
			case (paddr)
			`REG_CTRL: ctrl <= {pwdata[31:1], 1'b0};
			`REG_FREQ_LIM: freq_lim <= pwdata;
			`REG_RPM_LIM: rpm_lim <= pwdata;
			`REG_RPM_OVER: rpm_over <= pwdata;
			`REG_VOLT_LIM: volt_lim <= pwdata;
			`REG_BATT_LIM: batt_lim <= pwdata;
			`REG_CHARGE_LIM: charge_lim <= pwdata;
			`REG_UNBAL_LIM: unbal_lim <= pwdata;
			`REG_OC_LIM: oc_lim <= pwdata;
			`REG_DELAY_A: delay_a <= pwdata;
			`REG_DELAY_B: delay_b <= pwdata;
			`REG_START: start_cfg <= pwdata;
			`REG_SERVICE: service_cfg <= pwdata;
			default: ctrl <= ctrl;
			endcase
		end
	end

	// read data is prepared in the setup phase so prdata comes from a flop
	always @* begin
		next_pslverr = 1'b0;
		case (paddr)
		`REG_CTRL: next_prdata = ctrl;
		`REG_FREQ_LIM: next_prdata = freq_lim;
		`REG_RPM_LIM: next_prdata = rpm_lim;
		`REG_RPM_OVER: next_prdata = rpm_over;
		`REG_VOLT_LIM: next_prdata = volt_lim;
		`REG_BATT_LIM: next_prdata = batt_lim;
		`REG_CHARGE_LIM: next_prdata = charge_lim;
		`REG_UNBAL_LIM: next_prdata = unbal_lim;
		`REG_OC_LIM: next_prdata = oc_lim;
		`REG_DELAY_A: next_prdata = delay_a;
		`REG_DELAY_B: next_prdata = delay_b;
		`REG_START: next_prdata = start_cfg;
		`REG_SERVICE: next_prdata = service_cfg;
		`REG_STATUS: next_prdata = {{(32-`NA){1'b0}}, alarm_flags};
		`REG_SERVICE_USED: next_prdata = {days_used, hours_used};
		default: begin
			next_prdata = `ZERO_RESET;
			next_pslverr = 1'b1;
		end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `ZERO_RESET;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= pwrite ? `ZERO_RESET : next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// common 1 ms timebase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == TICK_LAST);
			tick_cnt <= (tick_cnt == TICK_LAST) ? 17'h00000 : tick_cnt + 17'h00001;
		end
	end

	// key pins are asynchronous to pclk
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_sync <= 2'h0;
			test_sync <= 2'h0;
		end else begin
			mute_sync <= {mute_sync[0], key_mute};
			test_sync <= {test_sync[0], key_test};
		end
	end

	wire [15:0] imax_a = (curr_l1 > curr_l2) ? curr_l1 : curr_l2;
	wire [15:0] imax = (imax_a > curr_l3) ? imax_a : curr_l3;
	wire [16:0] oc_l = {1'b0, oc_lim[15:0]};
	wire [31:0] ftrip_ext = {16'h0000, freq_lim[31:16]} * `OVER_FREQ_PCT / `PCT_DIV;
	wire [16:0] freq_trip = {1'b0, freq_lim[31:16]} + ftrip_ext[16:0];
	wire [15:0] oc_k = oc_lim[31:16];
	// permitted time shortens in steps as the excess grows
	wire [15:0] idmt_time = ({1'b0, imax} >= {oc_l[15:0], 1'b0}) ? {2'h0, oc_k[15:2]} :
		({1'b0, imax} >= oc_l + {2'h0, oc_l[15:1]}) ? {1'b0, oc_k[15:1]} : oc_k;

	wire [`NT-1:0] tcond;
	wire [`NT-1:0] texp;
	wire [15:0] tlim [0:`NT-1];
	wire armed = texp[`T_HOLD];

	assign tcond[`T_HOLD] = engine_running;
	assign tlim[`T_HOLD] = delay_a[15:0];
	assign tcond[`T_FREQ] = armed && out_of_window(freq, freq_lim);
	assign tlim[`T_FREQ] = delay_a[31:16];
	assign tcond[`T_RPM] = armed && out_of_window(rpm, rpm_lim);
	assign tlim[`T_RPM] = delay_a[31:16];
	assign tcond[`T_VOLT] = armed && (out_of_window(volt_l1, volt_lim) ||
		out_of_window(volt_l2, volt_lim) || out_of_window(volt_l3, volt_lim));
	assign tlim[`T_VOLT] = delay_b[15:0];
	assign tcond[`T_BATT] = out_of_window(batt, batt_lim);
	assign tlim[`T_BATT] = delay_a[31:16];
	assign tcond[`T_CHARGE] = armed && (charge < charge_lim[15:0]);
	assign tlim[`T_CHARGE] = delay_a[31:16];
	assign tcond[`T_VUNBAL] = armed &&
		unbalanced(volt_l1, volt_l2, volt_l3, unbal_lim[15:0]);
	assign tlim[`T_VUNBAL] = delay_b[15:0];
	assign tcond[`T_IUNBAL] = armed &&
		unbalanced(curr_l1, curr_l2, curr_l3, unbal_lim[31:16]);
	assign tlim[`T_IUNBAL] = delay_a[31:16];
	assign tcond[`T_ECU] = fuel_on && !ecu_msg;
	assign tlim[`T_ECU] = ECU_TICKS;
	assign tcond[`T_STOP] = stop_cmd && engine_running;
	assign tlim[`T_STOP] = delay_b[31:16];
	assign tcond[`T_KEYS] = mute_sync[1] && test_sync[1];
	assign tlim[`T_KEYS] = KEY_TICKS;
	assign tcond[`T_OC] = ({1'b0, imax} > oc_l);
	assign tlim[`T_OC] = idmt_time;

	// one saturating tick counter per fault timer
	genvar gi;
	generate
		for (gi = 0; gi < `NT; gi = gi + 1) begin : g_timer
			reg [15:0] cnt;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt <= 16'h0000;
				end else if (!tcond[gi]) begin
					cnt <= 16'h0000;
				end else if (tick && cnt != 16'hffff) begin
					cnt <= cnt + 16'h0001;
				end
			end
			assign texp[gi] = tcond[gi] && (cnt >= tlim[gi]);
		end
	endgenerate

	// start attempts are counted while a start request stands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			attempts <= 4'h0;
		end else if (!start_cmd || engine_running) begin
			attempts <= 4'h0;
		end else if (crank_end && attempts != 4'hf) begin
			attempts <= attempts + 4'h1;
		end
	end

	wire start_fail = start_cmd && !engine_running && (start_cfg[3:0] != 4'h0) &&
		(attempts >= start_cfg[3:0]);

	// service usage; a zero limit leaves that half of the counter unused
	wire keys_done = texp[`T_KEYS];
	wire svc_hours_exp = (service_cfg[15:0] != 16'h0000) &&
		(hours_used >= service_cfg[15:0]);
	wire svc_days_exp = (service_cfg[31:16] != 16'h0000) &&
		(days_used >= service_cfg[31:16]);
	assign service_request = svc_hours_exp || svc_days_exp;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hours_used <= 16'h0000;
			days_used <= 16'h0000;
			keys_done_d <= 1'b0;
			service_reset_done <= 1'b0;
		end else begin
			keys_done_d <= keys_done;
			service_reset_done <= keys_done && !keys_done_d;
			if (keys_done && !keys_done_d) begin
				hours_used <= 16'h0000;
				days_used <= 16'h0000;
			end else begin
				if (hour_tick && hours_used != 16'hffff) begin
					hours_used <= hours_used + 16'h0001;
				end
				if (day_tick && days_used != 16'hffff) begin
					days_used <= days_used + 16'h0001;
				end
			end
		end
	end

	reg [`NA-1:0] raw;
	always @* begin
		raw = {`NA{1'b0}};
		raw[`A_FREQ] = texp[`T_FREQ];
		raw[`A_RPM] = texp[`T_RPM];
		raw[`A_VOLT] = texp[`T_VOLT];
		raw[`A_BATT] = texp[`T_BATT];
		raw[`A_START] = start_fail;
		raw[`A_STOP] = texp[`T_STOP];
		raw[`A_CHARGE] = texp[`T_CHARGE];
		raw[`A_ECU] = texp[`T_ECU];
		raw[`A_VUNBAL] = texp[`T_VUNBAL];
		raw[`A_IUNBAL] = texp[`T_IUNBAL];
		raw[`A_OC] = texp[`T_OC];
		raw[`A_SERVICE] = service_request;
		raw[`A_FREQ_OVER] = ({1'b0, freq} > freq_trip);
		raw[`A_RPM_OVER] = (rpm > rpm_over[15:0]);
	end

	// a fault present during acknowledge stays latched: set wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_flags <= {`NA{1'b0}};
		end else if (ack) begin
			alarm_flags <= raw;
		end else begin
			alarm_flags <= alarm_flags | raw;
		end
	end

	wire [`NA-1:0] shut_m = level_mask(`ACT_SHUTDOWN, ctrl);
	wire [`NA-1:0] dump_m = level_mask(`ACT_LOADDUMP, ctrl);
	wire [`NA-1:0] warn_m = level_mask(`ACT_WARNING, ctrl);

	assign shutdown_alarm = |(alarm_flags & shut_m);
	assign stop_request = shutdown_alarm;
	assign loaddump_alarm = |(alarm_flags & dump_m);
	assign warning_alarm = |(alarm_flags & warn_m);

endmodule

// ### test/genset_supervisor_chk.sv
// port-level assertions for the genset supervisor
`timescale 1ns/10ps
module genset_supervisor_chk (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire pslverr,
	input wire engine_running,
	input wire fuel_on,
	input wire ecu_msg,
	input wire stop_cmd,
	input wire key_mute,
	input wire key_test,
	input wire [13:0] alarm_flags,
	input wire stop_request,
	input wire service_reset_done
);
	wire ack_now = psel && penable && pwrite && paddr == 8'h00 && pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence bad_setup;
		psel && !penable && paddr > 8'h38;
	endsequence
	sequence ecu_quiet;
		!alarm_flags[7] [*8];
	endsequence
	chk_flag_latch: assert property (!ack_now |=> ($past(alarm_flags) & ~alarm_flags) == 14'h0)
		else $error("alarm flag dropped without acknowledge");
	chk_ecu_fuel: assert property ($rose(alarm_flags[7]) |-> $past(fuel_on))
		else $error("ecu alarm raised with fuel off");
	chk_ecu_restart: assert property (ecu_msg && !alarm_flags[7] |=> ecu_quiet)
		else $error("ecu alarm right after a message");
	chk_start_fail: assert property ($rose(alarm_flags[4]) |-> $past(!engine_running))
		else $error("start fail while running");
	chk_stop_fail: assert property ($rose(alarm_flags[5]) |-> $past(engine_running && stop_cmd))
		else $error("stop fail without running stop");
	chk_key_hold: assert property (service_reset_done |-> ($past(key_mute, 3) && $past(key_test, 3)) ##1 !service_reset_done)
		else $error("service reset without both keys");
	chk_rpm_gate: assert property ($rose(alarm_flags[1]) |-> $past(engine_running))
		else $error("speed alarm while stopped");
	chk_over_stop: assert property ($rose(alarm_flags[12]) || $rose(alarm_flags[13]) |-> stop_request)
		else $error("overshoot without stop request");
	chk_bad_addr: assert property (bad_setup |=> pslverr)
		else $error("unmapped access not errored");
endmodule

bind genset_shutdown_alarm_supervisor genset_supervisor_chk i_chk (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.pslverr(pslverr), .engine_running(engine_running), .fuel_on(fuel_on), .ecu_msg(ecu_msg),
	.stop_cmd(stop_cmd), .key_mute(key_mute), .key_test(key_test), .alarm_flags(alarm_flags),
	.stop_request(stop_request), .service_reset_done(service_reset_done));

// ### test/genset_engine_model.sv
// behavioural engine and engine controller on the far side
`timescale 1ns/10ps
module genset_engine_model (
	input wire pclk,
	input wire presetn,
	input wire start_cmd,
	input wire stop_cmd,
	input wire fuel_on,
	input wire will_start,
	input wire ecu_alive,
	output reg engine_running,
	output reg crank_end,
	output reg ecu_msg
);
	reg [4:0] crank_cnt;
	reg [4:0] msg_cnt;
	wire cranking = start_cmd && !engine_running;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crank_cnt <= 5'h00;
			msg_cnt <= 5'h00;
			engine_running <= 1'b0;
			crank_end <= 1'b0;
			ecu_msg <= 1'b0;
		end else begin
			crank_cnt <= cranking ? crank_cnt + 5'h01 : 5'h00;
			crank_end <= cranking && crank_cnt == 5'h1f;
			// a stubborn engine neither starts nor stops, for the failure cases
			if (cranking && crank_cnt == 5'h1f && will_start) begin
				engine_running <= 1'b1;
			end else if (stop_cmd && will_start) begin
				engine_running <= 1'b0;
			end
			msg_cnt <= msg_cnt + 5'h01;
			ecu_msg <= fuel_on && ecu_alive && msg_cnt == 5'h00;
		end
	end
endmodule

// ### test/genset_shutdown_alarm_supervisor_test.sv
// self-checking bench for the genset supervisor
`timescale 1ns/10ps
`include "genset_supervisor_defs.vh"
module genset_shutdown_alarm_supervisor_test;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [31:0] pwdata = 32'h0;
	reg fuel_on = 1'b0, start_cmd = 1'b0, stop_cmd = 1'b0, hour_tick = 1'b0;
	reg key_mute = 1'b0, key_test = 1'b0, will_start = 1'b0, ecu_alive = 1'b0;
	reg [15:0] freq = 16'h0, rpm = 16'h0, volt = 16'h0, batt = 16'd150, curr = 16'h0;
	reg [15:0] dv = 16'h0, di = 16'h0, charge = 16'h00c8;
	wire [31:0] prdata;
	wire pready, pslverr, engine_running, ecu_msg, crank_end;
	wire stop_request, shutdown_alarm, loaddump_alarm, warning_alarm, service_request;
	wire [4:0] lvl = {stop_request, shutdown_alarm, loaddump_alarm, warning_alarm, service_request};
	reg [4:0] lvl_q[$];
	reg lvl_go = 1'b0;
	wire [`NA-1:0] alarm_flags;
	reg [32:0] exp_q[$];
	reg [32:0] e;
	reg [31:0] r = 32'hc695a83c;
	integer errors = 0, comparisons = 0, cycles = 0, i;

	initial forever #4 pclk = ~pclk;

	genset_shutdown_alarm_supervisor #(.TICK_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .engine_running(engine_running),
		.fuel_on(fuel_on), .ecu_msg(ecu_msg), .start_cmd(start_cmd), .crank_end(crank_end),
		.stop_cmd(stop_cmd), .hour_tick(hour_tick), .day_tick(hour_tick), .freq(freq), .rpm(rpm),
		.volt_l1(volt + dv), .volt_l2(volt), .volt_l3(volt), .batt(batt), .charge(charge),
		.curr_l1(curr + di), .curr_l2(curr), .curr_l3(curr), .key_mute(key_mute),
		.key_test(key_test), .alarm_flags(alarm_flags), .warning_alarm(warning_alarm),
		.loaddump_alarm(loaddump_alarm), .shutdown_alarm(shutdown_alarm),
		.stop_request(stop_request), .service_request(service_request), .service_reset_done());
	genset_engine_model i_eng (.pclk(pclk), .presetn(presetn), .start_cmd(start_cmd),
		.stop_cmd(stop_cmd), .fuel_on(fuel_on), .will_start(will_start), .ecu_alive(ecu_alive),
		.engine_running(engine_running), .crank_end(crank_end), .ecu_msg(ecu_msg));

	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task print_verdict;
		if (errors == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task cmp(input [32:0] got, input [32:0] want);
		comparisons = comparisons + 1;
		if (got !== want) begin
			errors = errors + 1;
			$display("BAD %0t read %h expected %h", $time, got, want);
		end
	endtask
	task cmp_lvl(input [4:0] got, input [4:0] want);
		comparisons = comparisons + 1;
		if (got !== want) begin
			errors = errors + 1;
			$display("BAD %0t levels %b expected %b", $time, got, want);
		end
	endtask
	// levels follow the latched flags, so one settled edge is enough to look at them
	task lv(input [4:0] w);
		lvl_q.push_back(w);
		lvl_go <= 1'b1;
		cyc(1);
		lvl_go <= 1'b0;
		cyc(1);
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge pclk);
	endtask
	// the idle cycle at the end keeps back-to-back calls from reassigning psel in one step
	task apb(input [7:0] a, input w, input [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task rd(input [7:0] a, input [31:0] d, input err);
		exp_q.push_back({err, d});
		apb(a, 1'b0, 32'h0);
	endtask
	task hour;
		hour_tick <= 1'b1;
		cyc(1);
		hour_tick <= 1'b0;
		cyc(1);
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			errors = errors + 1;
			print_verdict;
		end
	end
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = exp_q.pop_front();
			cmp({pslverr, prdata}, e);
		end
		if (lvl_go) begin
			cmp_lvl(lvl, lvl_q.pop_front());
		end
	end

	initial begin
		cyc(3);
		presetn <= 1'b1;
		cyc(1);
		rd(`REG_CTRL, `CTRL_RESET, 1'b0);
		rd(`REG_FREQ_LIM, `WINDOW_RESET, 1'b0);
		rd(`REG_DELAY_A, `ZERO_RESET, 1'b0);
		rd(8'h40, 32'h0, 1'b1);
		wr(`REG_STATUS, 32'hffffffff);
		rd(`REG_STATUS, 32'h0, 1'b0);
		for (i = 0; i < 3; i = i + 1) begin
			r = lfsr(r);
			wr(`REG_UNBAL_LIM, r);
			rd(`REG_UNBAL_LIM, r, 1'b0);
		end
		wr(`REG_FREQ_LIM, {16'd1000, 16'd0});
		rd(`REG_FREQ_LIM, 32'h03e80000, 1'b0);
		freq <= 16'd1120;
		cyc(3);
		rd(`REG_STATUS, 32'h0, 1'b0);
		freq <= 16'd1121;
		cyc(3);
		freq <= 16'd500;
		rd(`REG_STATUS, 1 << `A_FREQ_OVER, 1'b0);
		lv(5'h18);
		wr(`REG_CTRL, 32'h1);
		rd(`REG_STATUS, 32'h0, 1'b0);
		wr(`REG_RPM_OVER, 32'd3000);
		rpm <= 16'd3001;
		cyc(3);
		rpm <= 16'd50;
		rd(`REG_STATUS, 1 << `A_RPM_OVER, 1'b0);
		wr(`REG_CTRL, 32'h1);
		wr(`REG_DELAY_A, {16'd5, 16'd0});
		wr(`REG_BATT_LIM, {16'd200, 16'd100});
		batt <= 16'd50;
		cyc(12);
		batt <= 16'd150;
		cyc(4);
		batt <= 16'd250;
		cyc(12);
		batt <= 16'd150;
		rd(`REG_STATUS, 32'h0, 1'b0);
		batt <= 16'd250;
		cyc(40);
		batt <= 16'd150;
		rd(`REG_STATUS, 1 << `A_BATT, 1'b0);
		wr(`REG_CTRL, 32'h1);
		wr(`REG_START, 32'd2);
		start_cmd <= 1'b1;
		cyc(40);
		rd(`REG_STATUS, 32'h0, 1'b0);
		cyc(30);
		rd(`REG_STATUS, 1 << `A_START, 1'b0);
		start_cmd <= 1'b0;
		wr(`REG_CTRL, 32'h1);
		wr(`REG_RPM_LIM, {16'd2000, 16'd100});
		wr(`REG_DELAY_A, {16'd5, 16'd10});
		will_start <= 1'b1;
		start_cmd <= 1'b1;
		cyc(40);
		start_cmd <= 1'b0;
		rd(`REG_STATUS, 32'h0, 1'b0);
		cyc(100);
		rpm <= 16'd1000;
		rd(`REG_STATUS, 1 << `A_RPM, 1'b0);
		wr(`REG_CTRL, 32'h1);
		wr(`REG_DELAY_B, {16'd5, 16'd5});
		wr(`REG_UNBAL_LIM, {16'd20, 16'd20});
		wr(`REG_CHARGE_LIM, 32'd100);
		volt <= 16'd230;
		charge <= 16'd50;
		dv <= 16'd40;
		di <= 16'd40;
		cyc(40);
		charge <= 16'h00c8;
		dv <= 16'h0;
		di <= 16'h0;
		rd(`REG_STATUS, (1 << `A_CHARGE) | (1 << `A_VUNBAL) | (1 << `A_IUNBAL),
			1'b0);
		lv(5'h1a);
		wr(`REG_CTRL, 32'h1);
		wr(`REG_VOLT_LIM, {16'd250, 16'd200});
		dv <= 16'd30;
		cyc(40);
		dv <= 16'h0;
		rd(`REG_STATUS, 1 << `A_VOLT, 1'b0);
		wr(`REG_CTRL, 32'h1);
		will_start <= 1'b0;
		stop_cmd <= 1'b1;
		cyc(40);
		rd(`REG_STATUS, 1 << `A_STOP, 1'b0);
		will_start <= 1'b1;
		cyc(2);
		stop_cmd <= 1'b0;
		wr(`REG_CTRL, 32'h1);
		rd(`REG_STATUS, 32'h0, 1'b0);
		cyc(12400);
		rd(`REG_STATUS, 32'h0, 1'b0);
		fuel_on <= 1'b1;
		ecu_alive <= 1'b1;
		cyc(12400);
		rd(`REG_STATUS, 32'h0, 1'b0);
		ecu_alive <= 1'b0;
		cyc(12400);
		fuel_on <= 1'b0;
		rd(`REG_STATUS, 1 << `A_ECU, 1'b0);
		wr(`REG_CTRL, 32'h11);
		rd(`REG_CTRL, 32'h10, 1'b0);
		wr(`REG_OC_LIM, {16'd8, 16'd100});
		curr <= 16'd120;
		cyc(16);
		curr <= 16'd0;
		rd(`REG_STATUS, 32'h0, 1'b0);
		curr <= 16'd250;
		cyc(16);
		curr <= 16'd0;
		rd(`REG_STATUS, 1 << `A_OC, 1'b0);
		lv(5'h04);
		wr(`REG_CTRL, 32'h81);
		wr(`REG_SERVICE, {16'd0, 16'd2});
		hour;
		rd(`REG_STATUS, 32'h0, 1'b0);
		hour;
		rd(`REG_STATUS, 1 << `A_SERVICE, 1'b0);
		lv(5'h19);
		rd(`REG_SERVICE_USED, 32'h00020002, 1'b0);
		key_mute <= 1'b1;
		key_test <= 1'b1;
		cyc(20040);
		key_mute <= 1'b0;
		key_test <= 1'b0;
		rd(`REG_SERVICE_USED, 32'h0, 1'b0);
		wr(`REG_CTRL, 32'h1);
		rd(`REG_STATUS, 32'h0, 1'b0);
		lv(5'h00);
		print_verdict;
	end
endmodule
